/* File: design/cfis_pkg.sv */
/*
 * Constants for the low half of the interrupt event flag block:
 * register offsets, flag bit positions and reset values.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package cfis_pkg;

    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0] CFIS_SRC_OFF = 8'h00;
    localparam logic [7:0] CFIS_FLAGS_OFF = 8'h1c;
    localparam logic [7:0] CFIS_ENABLE_OFF = 8'h20;
    localparam logic [7:0] CFIS_CLEAR_OFF = 8'h24;
    localparam logic [7:0] CFIS_WMARK_OFF = 8'h28;

    // =========================================================
    // field layout
    localparam int CFIS_NFLAGS = 13;
    localparam int CFIS_CORE_EN_BIT = 1;
    localparam int CFIS_FIFO_W = 6;
    localparam int B_WMARK = 12;
    localparam int B_WAKE = 11;
    localparam int B_SLEEP = 10;
    localparam int B_BUSOFF = 9;
    localparam int B_ERROR = 8;
    localparam int B_OFLOW = 6;
    localparam int B_RECEIVE_COMPLETE = 4;
    localparam int B_RECOV = 3;
    localparam int B_PEE = 2;
    localparam int B_TRANSMIT_COMPLETE = 1;
    localparam int B_ARB = 0;

    // flags wiped when the core enable goes low; watermark excluded
    localparam logic [12:0] CFIS_CEN_CLR_MASK = 13'h0f5f;
    // implemented flags; bits 7 and 5 stay zero
    localparam logic [12:0] CFIS_IMPL_MASK = 13'h1f5f;

    // =========================================================
    // reset values
    localparam logic [31:0] CFIS_RST_ZERO = 32'h0000_0000;
    localparam logic [CFIS_FIFO_W-1:0] CFIS_WMARK_RST = 6'h0f;

    // controller mode
    typedef enum logic [1:0] {
        CFIS_MODE_CONFIG,
        CFIS_MODE_NORMAL,
        CFIS_MODE_SLEEP,
        CFIS_MODE_LOOP
    } cfis_mode_t;

endpackage

/* File: design/cfis_top.sv */
/*
 * Low half of the interrupt event flag register of a CAN FD
 * controller: sticky flags, write-one-to-clear, enable mask, irq.
 * Assumes the protocol engine gives one-cycle event pulses and
 * mode / fifo level as levels synchronous to clk_i.
 */
// Operation
// - watermark flag while fifo above watermark
// - wake flag on sleep to normal
// - sleep flag on entering sleep
// - bus-off flag on entering bus-off
// - error flag on protocol error
// - overflow flag when full fifo gets id in sequential fifo mode
// - receive flag on good stored message
// - recovery flag when bus-off recovery ends
// - exception flag on protocol exception event
// - transmit flag on successful transmission
// - arbitration flag on lost arbitration
// - flags stay until cleared by software
// - core enable low wipes all but watermark
// - loopback message sets receive and transmit
// - loopback receive flag precedes transmit flag
// - set beats clear in same cycle
// - clear by writing one, reads zero
// - irq only for enabled set flags
module cfis_top
    import cfis_pkg::*;
#(
    parameter int FIFO_W = CFIS_FIFO_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // protocol engine status
    input wire logic [1:0] mode_i,
    input wire logic [FIFO_W-1:0] rx_fifo_level_i,
    input wire logic bus_off_i,
    input wire logic error_i,
    input wire logic rx_fifo_full_i,
    input wire logic seq_fifo_mode_i,
    input wire logic new_id_i,
    input wire logic receive_complete_i,
    input wire logic bus_off_recovered_i,
    input wire logic protocol_exception_i,
    input wire logic transmit_complete_i,
    input wire logic arbitration_lost_i,
    // outputs to the core
    output logic core_enable_o,
    output logic irq_o
);

    // =========================================================
    // apb decode
    logic setup_w, wr_w, rd_w, hit_w;
    logic [12:0] flags_q, flags_set_w, enable_q, clear_w;
    logic [FIFO_W-1:0] wmark_q;
    logic core_enable_q, cen_clr_w, busoff_q, tx_pend_q;
    cfis_mode_t mode_q;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == CFIS_SRC_OFF) || (a == CFIS_FLAGS_OFF) || (a == CFIS_ENABLE_OFF)
            || (a == CFIS_CLEAR_OFF) || (a == CFIS_WMARK_OFF);
    endfunction

    // no wait state: answer in the first access cycle's next edge
    assign setup_w = psel_i && !penable_i;
    assign hit_w = addr_hit(paddr_i);
    assign wr_w = psel_i && penable_i && pready_o && pwrite_i && hit_w;
    assign rd_w = setup_w && !pwrite_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup_w;
            pslverr_o <= setup_w && !hit_w;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= CFIS_RST_ZERO;
        end else if (rd_w) begin
            case (paddr_i)
                CFIS_SRC_OFF: prdata_o <= {30'h0, core_enable_q, 1'b0};
                CFIS_FLAGS_OFF: prdata_o <= {19'h0, flags_q & CFIS_IMPL_MASK};
                CFIS_ENABLE_OFF: prdata_o <= {19'h0, enable_q};
                CFIS_WMARK_OFF: prdata_o <= {{(32-FIFO_W){1'b0}}, wmark_q};
                default: prdata_o <= CFIS_RST_ZERO;
            endcase
        end else if (setup_w) begin
            prdata_o <= CFIS_RST_ZERO;
        end
    end

    // =========================================================
    // control registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_enable_q <= 1'b0;
            enable_q <= 13'h0;
            wmark_q <= CFIS_WMARK_RST;
        end else if (wr_w) begin
            if (paddr_i == CFIS_SRC_OFF) core_enable_q <= pwdata_i[CFIS_CORE_EN_BIT];
            if (paddr_i == CFIS_ENABLE_OFF) enable_q <= pwdata_i[12:0] & CFIS_IMPL_MASK;
            if (paddr_i == CFIS_WMARK_OFF) wmark_q <= pwdata_i[FIFO_W-1:0];
        end
    end
    assign core_enable_o = core_enable_q;

    // clear is a write strobe only, nothing is stored
    assign clear_w = (wr_w && paddr_i == CFIS_CLEAR_OFF) ? pwdata_i[12:0] : 13'h0;
    assign cen_clr_w = wr_w && paddr_i == CFIS_SRC_OFF && !pwdata_i[CFIS_CORE_EN_BIT];

    // =========================================================
    // event detection
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= CFIS_MODE_CONFIG;
            busoff_q <= 1'b0;
        end else begin
            mode_q <= cfis_mode_t'(mode_i);
            busoff_q <= bus_off_i;
        end
    end

    // in loopback the transmit flag follows the receive one cycle later
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_pend_q <= 1'b0;
        end else begin
            tx_pend_q <= transmit_complete_i && mode_i == CFIS_MODE_LOOP;
        end
    end

    always_comb begin
        flags_set_w = 13'h0;
        flags_set_w[B_WMARK] = rx_fifo_level_i > wmark_q;
        flags_set_w[B_WAKE] = mode_q == CFIS_MODE_SLEEP && mode_i == CFIS_MODE_NORMAL;
        flags_set_w[B_SLEEP] = mode_q != CFIS_MODE_SLEEP && mode_i == CFIS_MODE_SLEEP;
        flags_set_w[B_BUSOFF] = bus_off_i && !busoff_q;
        flags_set_w[B_ERROR] = error_i;
        flags_set_w[B_OFLOW] = seq_fifo_mode_i && new_id_i && rx_fifo_full_i;
        flags_set_w[B_RECEIVE_COMPLETE] = receive_complete_i
            || (transmit_complete_i && mode_i == CFIS_MODE_LOOP);
        flags_set_w[B_RECOV] = bus_off_recovered_i;
        flags_set_w[B_PEE] = protocol_exception_i;
        flags_set_w[B_TRANSMIT_COMPLETE] = (transmit_complete_i && mode_i != CFIS_MODE_LOOP) || tx_pend_q;
        flags_set_w[B_ARB] = arbitration_lost_i;
    end

    // =========================================================
    // sticky flags: set wins over both clears
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_q <= 13'h0;
        end else begin
            flags_q <= ((flags_q & ~clear_w & ~(cen_clr_w ? CFIS_CEN_CLR_MASK : 13'h0))
                | flags_set_w) & CFIS_IMPL_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_q & enable_q);
        end
    end

    // =========================================================
    // checks
    a_wmark_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rx_fifo_level_i > wmark_q |=> flags_q[B_WMARK])
        else $error("watermark flag not set");
    a_wake_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flags_set_w[B_WAKE] |=> flags_q[B_WAKE])
        else $error("wake flag not set");
    a_sleep_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode_q != CFIS_MODE_SLEEP && mode_i == CFIS_MODE_SLEEP |=> flags_q[B_SLEEP])
        else $error("sleep flag not set");
    a_busoff_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(bus_off_i) |=> flags_q[B_BUSOFF])
        else $error("bus-off flag not set");
    a_error_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        error_i |=> flags_q[B_ERROR])
        else $error("error flag not set");
    a_oflow_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_fifo_mode_i && new_id_i && rx_fifo_full_i |=> flags_q[B_OFLOW])
        else $error("overflow flag not set");
    a_receive_complete_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        receive_complete_i |=> flags_q[B_RECEIVE_COMPLETE])
        else $error("receive flag not set");
    a_recov_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        bus_off_recovered_i |=> flags_q[B_RECOV])
        else $error("recovery flag not set");
    a_pee_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        protocol_exception_i |=> flags_q[B_PEE])
        else $error("exception flag not set");
    a_transmit_complete_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        transmit_complete_i |-> ##[1:2] flags_q[B_TRANSMIT_COMPLETE])
        else $error("transmit flag not set");
    a_arb_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        arbitration_lost_i |=> flags_q[B_ARB])
        else $error("arbitration flag not set");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flags_q[B_ERROR] && clear_w[B_ERROR] == 1'b0 && !cen_clr_w |=> flags_q[B_ERROR])
        else $error("flag dropped without clear");
    a_cen_wipe: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cen_clr_w && (flags_set_w & CFIS_CEN_CLR_MASK) == 13'h0 |=> (flags_q & CFIS_CEN_CLR_MASK) == 13'h0)
        else $error("core disable did not wipe flags");
    a_loop_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
        transmit_complete_i && mode_i == CFIS_MODE_LOOP |=> flags_q[B_RECEIVE_COMPLETE] ##1 flags_q[B_TRANSMIT_COMPLETE])
        else $error("loopback flag order wrong");
    a_set_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
        clear_w[B_ARB] && arbitration_lost_i |=> flags_q[B_ARB])
        else $error("clear beat set");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 irq_o == |($past(flags_q) & $past(enable_q)))
        else $error("irq mismatch");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flags_q[7] == 1'b0 && flags_q[5] == 1'b0)
        else $error("reserved flag set");

endmodule

/* File: tb/cfis_top_tb.sv */
/*
 * Self-checking bench for the low interrupt event flag block.
 * Assumes the design answers every apb access within a few cycles.
 */
module cfis_top_tb
    import cfis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

    // =========================================================
    // signals
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, core_enable_o, irq_o;
    logic [1:0] mode_i = CFIS_MODE_NORMAL;
    logic [5:0] lvl = 6'h00;
    logic bus_off = 1'b0;
    logic full = 1'b1;
    logic seq = 1'b1;
    // event pulses: arb, tx, pee, recov, rx, new id, error
    logic [6:0] ev = 7'h00;
    logic [12:0] evb [7] = '{13'h001, 13'h002, 13'h004, 13'h008, 13'h010, 13'h040, 13'h100};
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checks_done = 0;
    int n;

    always #2 clk_i = ~clk_i;

    cfis_top dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mode_i(mode_i), .rx_fifo_level_i(lvl), .bus_off_i(bus_off),
        .error_i(ev[6]), .rx_fifo_full_i(full), .seq_fifo_mode_i(seq), .new_id_i(ev[5]),
        .receive_complete_i(ev[4]), .bus_off_recovered_i(ev[3]), .protocol_exception_i(ev[2]),
        .transmit_complete_i(ev[1]), .arbitration_lost_i(ev[0]), .core_enable_o(core_enable_o),
        .irq_o(irq_o)
    );

    // =========================================================
    // bus and stimulus tasks
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (pready_o !== 1'b1) begin
            num_errors++;
            results();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK("read data", ex, rd)
    endtask

    task automatic pulse(input logic [6:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 7'h00;
        repeat (2) @(posedge clk_i);
    endtask

    // flag set, irq up, cleared by writing one, irq down
    task automatic ev_chk(input logic [12:0] ex);
        rd_chk(CFIS_FLAGS_OFF, {19'h0, ex});
        `CHK("irq set", 1'b1, irq_o)
        apb(1'b1, CFIS_CLEAR_OFF, {19'h0, ex});
        rd_chk(CFIS_FLAGS_OFF, 32'h0);
        `CHK("irq clear", 1'b0, irq_o)
    endtask

    // cycles from pulse launch until irq is seen
    task automatic irq_lat(input logic [6:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 7'h00;
        n = 1;
        while (irq_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // =========================================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd_chk(CFIS_FLAGS_OFF, 32'h0);
        rd_chk(CFIS_ENABLE_OFF, 32'h0);
        rd_chk(CFIS_CLEAR_OFF, 32'h0);
        rd_chk(CFIS_WMARK_OFF, 32'h0f);
        apb(1'b0, 8'h44, 32'h0);
        `CHK("slverr", 1'b1, err)
        apb(1'b1, CFIS_SRC_OFF, 32'h2);
        // the enable flop updates on the write edge, look one edge later
        @(posedge clk_i);
        `CHK("core enable", 1'b1, core_enable_o)
        apb(1'b1, CFIS_ENABLE_OFF, 32'h1fff);
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            ev_chk(evb[i]);
        end
        @(posedge clk_i) mode_i <= CFIS_MODE_SLEEP;
        ev_chk(13'h400);
        @(posedge clk_i) mode_i <= CFIS_MODE_NORMAL;
        ev_chk(13'h800);
        @(posedge clk_i) bus_off <= 1'b1;
        ev_chk(13'h200);
        bus_off <= 1'b0;
        full <= 1'b0;
        pulse(7'h20);
        rd_chk(CFIS_FLAGS_OFF, 32'h0);
        full <= 1'b1;
        seq <= 1'b0;
        pulse(7'h20);
        rd_chk(CFIS_FLAGS_OFF, 32'h0);
        seq <= 1'b1;
        // masked flag must not reach irq
        apb(1'b1, CFIS_ENABLE_OFF, 32'h1);
        pulse(7'h02);
        `CHK("irq masked", 1'b0, irq_o)
        pulse(7'h01);
        `CHK("irq enabled", 1'b1, irq_o)
        // clear and set land on the same edge
        fork
            apb(1'b1, CFIS_CLEAR_OFF, 32'h3);
            begin
                repeat (2) @(posedge clk_i);
                ev <= 7'h01;
                @(posedge clk_i);
                ev <= 7'h00;
            end
        join
        rd_chk(CFIS_FLAGS_OFF, 32'h1);
        apb(1'b1, CFIS_CLEAR_OFF, 32'h1);
        // watermark boundary, reserved bits, core disable
        lvl <= 6'h0f;
        bus_off <= 1'b1;
        mode_i <= CFIS_MODE_SLEEP;
        pulse(7'h7f);
        mode_i <= CFIS_MODE_NORMAL;
        rd_chk(CFIS_FLAGS_OFF, 32'h0f5f);
        lvl <= 6'h10;
        pulse(7'h00);
        rd_chk(CFIS_FLAGS_OFF, 32'h1f5f);
        apb(1'b1, CFIS_SRC_OFF, 32'h0);
        @(posedge clk_i);
        `CHK("core disable", 1'b0, core_enable_o)
        rd_chk(CFIS_FLAGS_OFF, 32'h1000);
        apb(1'b1, CFIS_CLEAR_OFF, 32'h1000);
        rd_chk(CFIS_FLAGS_OFF, 32'h1000);
        lvl <= 6'h0a;
        bus_off <= 1'b0;
        apb(1'b1, CFIS_CLEAR_OFF, 32'h1000);
        rd_chk(CFIS_FLAGS_OFF, 32'h0);
        // loopback: receive flag one cycle ahead of transmit
        apb(1'b1, CFIS_SRC_OFF, 32'h2);
        mode_i <= CFIS_MODE_LOOP;
        apb(1'b1, CFIS_ENABLE_OFF, 32'h10);
        irq_lat(7'h02);
        `CHK("rx latency", 3, n)
        rd_chk(CFIS_FLAGS_OFF, 32'h12);
        apb(1'b1, CFIS_CLEAR_OFF, 32'h12);
        apb(1'b1, CFIS_ENABLE_OFF, 32'h2);
        irq_lat(7'h02);
        `CHK("tx latency", 4, n)
        results();
    end
endmodule
